/* File: lhs_host.sv */
// Purpose: host microcontroller model on the register port
// Assumes: one access at a time, lines change just after a falling edge
// Notes:   released address and data lines carry the inverse of the last value
`timescale 1ns/1ns
module lhs_host (
	input  wire logic       core_clk,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [6:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	// idle bus from time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 8'h00;
	end

	// one-cycle strobe; scrambled lines so a stale value never looks valid
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr

	// answer is registered and held, taken one full cycle later
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge core_clk);
		d = reg_rdata;
	endtask : rd

	// refresh always carries the time-out setting in the same write
	task automatic refresh(input logic [2:0] sel);
		wr(lhs_pkg::LHS_ADDR_FB, {1'b0, lhs_pkg::LHS_EXIT_REFRESH, sel, 1'b0});
	endtask : refresh

	// exit steps keep the longest time-out for the way back
	task automatic leave();
		wr(lhs_pkg::LHS_ADDR_FB, {1'b0, lhs_pkg::LHS_EXIT_STEP1, 3'h7, 1'b0});
		wr(lhs_pkg::LHS_ADDR_FB, {1'b0, lhs_pkg::LHS_EXIT_STEP2, 3'h7, 1'b0});
		wr(lhs_pkg::LHS_ADDR_FB, {1'b0, lhs_pkg::LHS_EXIT_STEP3, 3'h7, 1'b0});
	endtask : leave

	// clear flags, issue command, poll a bounded number of times
	task automatic mem_cmd(input logic [7:0] cmd, output logic [7:0] f);
		wr(lhs_pkg::LHS_ADDR_DIAG, 8'h00);
		wr(lhs_pkg::LHS_ADDR_CMD, cmd);
		f = 8'h00;
		for (int i = 0; i < 32 && f[4:3] == 2'h0; i++) begin
			rd(lhs_pkg::LHS_ADDR_DIAG, f);
		end
	endtask : mem_cmd

	task automatic mem_wr(input logic [4:0] a, input logic [15:0] d, output logic [7:0] f);
		wr(lhs_pkg::LHS_ADDR_WLO, d[7:0]);
		wr(lhs_pkg::LHS_ADDR_WHI, d[15:8]);
		mem_cmd({3'h4, a}, f);
	endtask : mem_wr

	task automatic mem_rd(input logic [4:0] a, output logic [7:0] f, output logic [15:0] d);
		mem_cmd({3'h2, a}, f);
		rd(lhs_pkg::LHS_ADDR_RLO, d[7:0]);
		rd(lhs_pkg::LHS_ADDR_RHI, d[15:8]);
	endtask : mem_rd
endmodule : lhs_host

/* File: lhs_nvm.sv */
// Purpose: four-word fallback store with slow programming and registered read
// Assumes: one request at a time, requester waits for done
// Notes:   words come up with factory defaults after reset
`timescale 1ns/1ns
module lhs_nvm #(
	parameter int unsigned PROG_CYCLES = lhs_pkg::LHS_PROG_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [1:0]  addr,
	input  wire logic [15:0] wdata,
	output logic      [15:0] rdata,
	output logic             done
);

	logic [15:0] word [4];
	logic [23:0] prog_cnt;
	logic        prog_busy;
	logic [1:0]  prog_addr;
	logic [15:0] prog_data;
	wire         prog_end = prog_busy && (prog_cnt == 24'h000000);

	// programming runs its full time before the word changes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_busy <= 1'b0;
			prog_cnt  <= 24'h000000;
			prog_addr <= 2'h0;
			prog_data <= 16'h0000;
		end else if (ce) begin
			if (wr_en && !prog_busy) begin
				prog_busy <= 1'b1;
				prog_cnt  <= 24'(PROG_CYCLES - 1);
				prog_addr <= addr;
				prog_data <= wdata;
			end else if (prog_end) begin
				prog_busy <= 1'b0;
			end else if (prog_busy) begin
				prog_cnt <= prog_cnt - 24'h000001;
			end
		end
	end

	// storage and registered read port
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			word[0] <= lhs_pkg::LHS_NVM_DEF0;
			word[1] <= lhs_pkg::LHS_NVM_DEF1;
			word[2] <= lhs_pkg::LHS_NVM_DEF2;
			word[3] <= lhs_pkg::LHS_NVM_DEF3;
			rdata   <= 16'h0000;
			done    <= 1'b0;
		end else if (ce) begin
			if (prog_end)
				word[prog_addr] <= prog_data;
			if (rd_en)
				rdata <= word[addr];
			done <= prog_end || (rd_en && !prog_busy);
		end
	end

endmodule : lhs_nvm

/* File: lhs_pkg.sv */
// Purpose: shared constants for the limp-home supervisor and its memory
// Assumes: 125 MHz core clock, 7-bit register addresses, 8-bit register data
// Notes:   time-out unit and programming time are plain defaults, shortened by top parameters
package lhs_pkg;

	// register addresses
	localparam logic [6:0] LHS_ADDR_CMD  = 7'h17;
	localparam logic [6:0] LHS_ADDR_WLO  = 7'h18;
	localparam logic [6:0] LHS_ADDR_WHI  = 7'h19;
	localparam logic [6:0] LHS_ADDR_RLO  = 7'h28;
	localparam logic [6:0] LHS_ADDR_RHI  = 7'h29;
	localparam logic [6:0] LHS_ADDR_FB   = 7'h33;
	localparam logic [6:0] LHS_ADDR_DIAG = 7'h36;

	// fallback_control fields
	localparam int LHS_FB_STATUS_BIT = 7;
	localparam int LHS_FB_EXIT_LSB   = 4;
	localparam int LHS_FB_TMO_LSB    = 1;
	localparam int LHS_FB_CFG_BIT    = 0;
	localparam logic [2:0] LHS_EXIT_REFRESH = 3'h7;
	localparam logic [2:0] LHS_EXIT_STEP1   = 3'h1;
	localparam logic [2:0] LHS_EXIT_STEP2   = 3'h2;
	localparam logic [2:0] LHS_EXIT_STEP3   = 3'h4;
	localparam logic [2:0] LHS_TMO_RESET    = 3'h0;

	// memory_access_command fields
	localparam int LHS_CMD_WR_BIT   = 7;
	localparam int LHS_CMD_RD_BIT   = 6;
	localparam logic [4:0] LHS_NVM_BASE = 5'h10;
	localparam logic [4:0] LHS_NVM_LAST = 5'h13;

	// diagnostic_summary_two fields
	localparam int LHS_DIAG_FAIL_BIT = 4;
	localparam int LHS_DIAG_DONE_BIT = 3;

	// override field positions inside the pwm-control word
	localparam int LHS_OVR1_LSB = 1;
	localparam int LHS_OVR2_LSB = 3;

	// memory word values after reset (factory defaults)
	localparam logic [15:0] LHS_NVM_DEF0 = 16'h0000;
	localparam logic [15:0] LHS_NVM_DEF1 = 16'h9600;
	localparam logic [15:0] LHS_NVM_DEF2 = 16'h0000;
	localparam logic [15:0] LHS_NVM_DEF3 = 16'h002a;

	// mode-request pin encodings
	localparam logic [1:0] LHS_REQ_NONE   = 2'h0;
	localparam logic [1:0] LHS_REQ_ACCESS = 2'h1;
	localparam logic [1:0] LHS_REQ_USE    = 2'h2;
	localparam logic [1:0] LHS_REQ_UNUSED = 2'h3;

	// timing
	localparam int unsigned LHS_CLK_KHZ         = 125000;
	localparam int unsigned LHS_TMO_UNIT_MS     = 1;
	localparam int unsigned LHS_TMO_UNIT_CYCLES = LHS_TMO_UNIT_MS * LHS_CLK_KHZ;
	localparam int unsigned LHS_PROG_TIME_US    = 100;
	localparam int unsigned LHS_PROG_CYCLES     = (LHS_PROG_TIME_US * LHS_CLK_KHZ) / 1000;

	typedef enum logic [2:0] {
		LHS_NORMAL = 3'h0,
		LHS_LIMP   = 3'h1,
		LHS_ACCESS = 3'h3,
		LHS_USE    = 3'h2,
		LHS_UNUSED = 3'h6
	} lhs_mode_e;

	typedef enum logic [1:0] {
		LHS_E_IDLE  = 2'h0,
		LHS_E_LOAD  = 2'h1,
		LHS_E_WRITE = 2'h3,
		LHS_E_READ  = 2'h2
	} lhs_eng_e;

endpackage : lhs_pkg

/* File: lhs_supervisor.sv */
// Purpose: link-loss supervisor, fallback loader and memory access sequencer
// Assumes: register port driven by the serial frontend in the core clock domain
// Notes:   pins pass three flops; a level counts once the last two agree
`timescale 1ns/1ns

module lhs_supervisor #(
	parameter int unsigned TIMEOUT_UNIT_CYCLES = lhs_pkg::LHS_TMO_UNIT_CYCLES,
	parameter int unsigned PROG_CYCLES         = lhs_pkg::LHS_PROG_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [6:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic [1:0]  channel_dimming_input,
	input  wire logic        fail_silent_in,
	input  wire logic        undervoltage_in,
	input  wire logic [1:0]  mem_mode_req,
	output logic      [1:0]  ch_on,
	output logic             limp_status,
	output logic      [63:0] limp_values
);

	// address lies in the writable memory window
	function automatic logic lhs_window_ok(input logic [4:0] a);
		return (a >= lhs_pkg::LHS_NVM_BASE) && (a <= lhs_pkg::LHS_NVM_LAST);
	endfunction : lhs_window_ok

	// per-channel override decode
	function automatic logic lhs_override(input logic [1:0] code, input logic dim);
		case (code)
			2'h0:    return 1'b0;
			2'h2:    return 1'b1;
			default: return dim;
		endcase
	endfunction : lhs_override

	lhs_pkg::lhs_mode_e mode, next_mode;
	lhs_pkg::lhs_eng_e  eng;
	logic [5:0]  sync1, sync2, sync3, pin_f;
	logic [23:0] tmo_cnt;
	logic [2:0]  tmo_sel, exit_field;
	logic [1:0]  exit_step, load_idx, tog;
	logic        load_pend, fs_latched, done_flag, fail_flag;
	logic [7:0]  cmd, wlo, whi, rlo, rhi;
	logic [15:0] loaded [4];
	logic [15:0] mem_rdata;
	logic        mem_done;

	// pin filter: first flop feeds only the second
	wire [5:0] pin_raw    = {mem_mode_req, undervoltage_in, fail_silent_in, channel_dimming_input};
	wire [5:0] next_pin_f = ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & pin_f);
	wire [1:0] dim        = pin_f[1:0];
	wire       uv         = pin_f[3];
	wire [1:0] mreq       = pin_f[5:4];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
			sync3 <= 6'h00;
			pin_f <= 6'h00;
		end else if (ce) begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			pin_f <= next_pin_f;
		end
	end

	// register decode
	wire [2:0] wexit      = reg_wdata[lhs_pkg::LHS_FB_EXIT_LSB +: 3];
	wire       wr_fb      = reg_wr && (reg_addr == lhs_pkg::LHS_ADDR_FB);
	wire       wr_diag    = reg_wr && (reg_addr == lhs_pkg::LHS_ADDR_DIAG);
	wire       in_limp    = (mode == lhs_pkg::LHS_LIMP);
	wire       fb_wr_ok   = wr_fb && (mode != lhs_pkg::LHS_USE) && (mode != lhs_pkg::LHS_UNUSED);
	wire       gen_wr_ok  = reg_wr && !in_limp && (mode != lhs_pkg::LHS_UNUSED);
	wire       refresh    = fb_wr_ok && (mode == lhs_pkg::LHS_NORMAL) && (wexit == lhs_pkg::LHS_EXIT_REFRESH);
	wire       exit_done  = wr_fb && in_limp && (exit_step == 2'h2) && (wexit == lhs_pkg::LHS_EXIT_STEP3);
	wire [23:0] tmo_limit = 24'((32'(tmo_sel) + 32'd1) * TIMEOUT_UNIT_CYCLES);
	wire       tmo_hit    = (mode == lhs_pkg::LHS_NORMAL) && !refresh
	                        && (tmo_cnt >= tmo_limit - 24'h000001);

	// mode sequencing; use and not-in-use are left only by reset
	always_comb begin
		next_mode = mode;
		case (mode)
			lhs_pkg::LHS_NORMAL: begin
				if (mreq == lhs_pkg::LHS_REQ_ACCESS)
					next_mode = lhs_pkg::LHS_ACCESS;
				else if (mreq == lhs_pkg::LHS_REQ_USE)
					next_mode = lhs_pkg::LHS_USE;
				else if (mreq == lhs_pkg::LHS_REQ_UNUSED)
					next_mode = lhs_pkg::LHS_UNUSED;
				else if (tmo_hit)
					next_mode = lhs_pkg::LHS_LIMP;
			end
			lhs_pkg::LHS_LIMP: begin
				if (exit_done)
					next_mode = lhs_pkg::LHS_NORMAL;
			end
			lhs_pkg::LHS_ACCESS: begin
				if (mreq == lhs_pkg::LHS_REQ_NONE)
					next_mode = lhs_pkg::LHS_NORMAL;
				else if (mreq == lhs_pkg::LHS_REQ_USE)
					next_mode = lhs_pkg::LHS_USE;
				else if (mreq == lhs_pkg::LHS_REQ_UNUSED)
					next_mode = lhs_pkg::LHS_UNUSED;
			end
			lhs_pkg::LHS_USE:    next_mode = lhs_pkg::LHS_USE;
			lhs_pkg::LHS_UNUSED: next_mode = lhs_pkg::LHS_UNUSED;
			default:             next_mode = lhs_pkg::LHS_NORMAL;
		endcase
	end

	// mode, time-out counter and fallback control fields
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode       <= lhs_pkg::LHS_NORMAL;
			tmo_cnt    <= 24'h000000;
			tmo_sel    <= lhs_pkg::LHS_TMO_RESET;
			exit_field <= 3'h0;
			exit_step  <= 2'h0;
		end else if (ce) begin
			mode <= next_mode;
			if (refresh || exit_done)
				tmo_cnt <= 24'h000000;
			else if (mode == lhs_pkg::LHS_NORMAL && !tmo_hit)
				tmo_cnt <= tmo_cnt + 24'h000001; // frozen in other modes
			if (fb_wr_ok) begin
				tmo_sel    <= reg_wdata[lhs_pkg::LHS_FB_TMO_LSB +: 3];
				exit_field <= wexit;
			end
			if (!in_limp || exit_done)
				exit_step <= 2'h0;
			else if (wr_fb && wexit == lhs_pkg::LHS_EXIT_STEP1)
				exit_step <= 2'h1;
			else if (wr_fb && wexit == lhs_pkg::LHS_EXIT_STEP2 && exit_step == 2'h1)
				exit_step <= 2'h2;
			else if (wr_fb)
				exit_step <= 2'h0; // broken sequence starts over
		end
	end

	// memory engine requests
	wire [4:0] caddr   = reg_wdata[4:0];
	wire       cmd_go  = reg_wr && (reg_addr == lhs_pkg::LHS_ADDR_CMD)
	                     && (mode == lhs_pkg::LHS_USE) && (eng == lhs_pkg::LHS_E_IDLE);
	wire       c_wr    = reg_wdata[lhs_pkg::LHS_CMD_WR_BIT];
	wire       c_rd    = reg_wdata[lhs_pkg::LHS_CMD_RD_BIT] && !c_wr;
	wire       c_ok    = lhs_window_ok(caddr);
	wire       mem_wr  = cmd_go && c_wr && c_ok;
	wire       mem_rd  = (cmd_go && c_rd && c_ok) || (eng == lhs_pkg::LHS_E_LOAD && !load_pend);
	wire       reject  = cmd_go && (c_wr || c_rd) && !c_ok;
	wire       set_ok  = mem_done && (eng == lhs_pkg::LHS_E_WRITE || eng == lhs_pkg::LHS_E_READ);
	wire [1:0] mem_a   = (eng == lhs_pkg::LHS_E_LOAD) ? load_idx : caddr[1:0];
	wire       enter_l = (mode == lhs_pkg::LHS_NORMAL) && (next_mode == lhs_pkg::LHS_LIMP);

	lhs_nvm #(
		.PROG_CYCLES (PROG_CYCLES)
	) lhs_nvm_i (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.wr_en    (mem_wr),
		.rd_en    (mem_rd),
		.addr     (mem_a),
		.wdata    ({whi, wlo}),
		.rdata    (mem_rdata),
		.done     (mem_done)
	);

	// engine: host write/read, or fallback load of all four words
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			eng       <= lhs_pkg::LHS_E_IDLE;
			load_idx  <= 2'h0;
			load_pend <= 1'b0;
		end else if (ce) begin
			case (eng)
				lhs_pkg::LHS_E_IDLE: begin
					load_idx <= 2'h0;
					if (enter_l)
						eng <= lhs_pkg::LHS_E_LOAD;
					else if (mem_wr)
						eng <= lhs_pkg::LHS_E_WRITE;
					else if (mem_rd)
						eng <= lhs_pkg::LHS_E_READ;
				end
				lhs_pkg::LHS_E_LOAD: begin
					load_pend <= mem_rd || (load_pend && !mem_done);
					if (mem_done) begin
						load_idx <= load_idx + 2'h1;
						if (load_idx == 2'h3)
							eng <= lhs_pkg::LHS_E_IDLE;
					end
				end
				default: begin
					if (mem_done)
						eng <= lhs_pkg::LHS_E_IDLE;
				end
			endcase
		end
	end

	// staging, read-back, loaded copy and flags; a set beats a clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd <= 8'h00;
			wlo <= 8'h00;
			whi <= 8'h00;
			rlo <= 8'h00;
			rhi <= 8'h00;
			done_flag <= 1'b0;
			fail_flag <= 1'b0;
			tog <= 2'h0;
			for (int i = 0; i < 4; i++)
				loaded[i] <= 16'h0000;
		end else if (ce) begin
			if (gen_wr_ok && reg_addr == lhs_pkg::LHS_ADDR_CMD)
				cmd <= reg_wdata;
			if (gen_wr_ok && reg_addr == lhs_pkg::LHS_ADDR_WLO)
				wlo <= reg_wdata;
			if (gen_wr_ok && reg_addr == lhs_pkg::LHS_ADDR_WHI)
				whi <= reg_wdata;
			if (set_ok && eng == lhs_pkg::LHS_E_READ) begin
				rlo <= mem_rdata[7:0];
				rhi <= mem_rdata[15:8];
			end
			if (mem_done && eng == lhs_pkg::LHS_E_LOAD)
				loaded[load_idx] <= mem_rdata; // kept after exit
			done_flag <= set_ok || (done_flag && !wr_diag);
			fail_flag <= reject || (fail_flag && !wr_diag);
			tog <= (dim ^ next_pin_f[1:0]) | (tog & {2{!wr_diag}});
		end
	end

	// fail-silent is latched; undervoltage follows the pin
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			fs_latched <= 1'b0;
		else if (ce && pin_f[2])
			fs_latched <= 1'b1;
	end

	// channel drive; loading darkens briefly so no stale override shows
	wire [1:0] limp_drive = {lhs_override(loaded[3][lhs_pkg::LHS_OVR2_LSB +: 2], dim[1]),
	                         lhs_override(loaded[3][lhs_pkg::LHS_OVR1_LSB +: 2], dim[0])};
	wire       dim_modes  = (mode == lhs_pkg::LHS_NORMAL) || (mode == lhs_pkg::LHS_ACCESS);
	wire       ch_allow   = !fs_latched && !uv && !(in_limp && eng == lhs_pkg::LHS_E_LOAD);
	wire [1:0] next_ch_on = !ch_allow ? 2'h0 : in_limp ? limp_drive : dim_modes ? dim : 2'h0;
	wire       cfg_mode   = (mode == lhs_pkg::LHS_ACCESS) || (mode == lhs_pkg::LHS_USE)
	                        || (mode == lhs_pkg::LHS_UNUSED);
	wire [7:0] fb_rd      = {in_limp, exit_field, tmo_sel, cfg_mode};
	wire [7:0] diag_rd    = {3'h0, fail_flag, done_flag, 1'b0, tog};
	wire [7:0] next_rdata = (reg_addr == lhs_pkg::LHS_ADDR_CMD)  ? cmd :
	                        (reg_addr == lhs_pkg::LHS_ADDR_WLO)  ? wlo :
	                        (reg_addr == lhs_pkg::LHS_ADDR_WHI)  ? whi :
	                        (reg_addr == lhs_pkg::LHS_ADDR_RLO)  ? rlo :
	                        (reg_addr == lhs_pkg::LHS_ADDR_RHI)  ? rhi :
	                        (reg_addr == lhs_pkg::LHS_ADDR_FB)   ? fb_rd :
	                        (reg_addr == lhs_pkg::LHS_ADDR_DIAG) ? diag_rd : 8'h00;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ch_on     <= 2'h0;
			reg_rdata <= 8'h00;
		end else if (ce) begin
			ch_on <= next_ch_on;
			if (reg_rd)
				reg_rdata <= next_rdata;
		end
	end

	assign limp_status = in_limp;
	assign limp_values = {loaded[3], loaded[2], loaded[1], loaded[0]};

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_refresh;
		ce && refresh;
	endsequence
	sequence s_restart;
		tmo_cnt == 24'h000000 && tmo_sel == $past(reg_wdata[3:1]);
	endsequence

	limp_entry_a: assert property (ce && tmo_hit && mreq == 2'h0 |=> in_limp)
		else $error("time-out did not enter fallback mode");
	status_bit_a: assert property (ce && reg_rd && reg_addr == lhs_pkg::LHS_ADDR_FB
		|=> reg_rdata[7] == $past(in_limp))
		else $error("status bit disagrees with mode");
	limp_lock_a: assert property (ce && in_limp && reg_wr && reg_addr == lhs_pkg::LHS_ADDR_WLO
		|=> wlo == $past(wlo))
		else $error("locked register changed in fallback mode");
	exit_seq_a: assert property (ce && exit_done |=> mode == lhs_pkg::LHS_NORMAL ##0 exit_step == 2'h0)
		else $error("completed exit sequence did not leave fallback");
	exit_early_a: assert property (ce && in_limp && wr_fb && exit_step != 2'h2 |=> in_limp)
		else $error("fallback left without full sequence");
	timer_hold_a: assert property (ce && mode == lhs_pkg::LHS_ACCESS |=> tmo_cnt == $past(tmo_cnt))
		else $error("time-out counter ran in access mode");
	use_dark_a: assert property (ce && mode == lhs_pkg::LHS_USE |=> ch_on == 2'h0 ##1 mode == lhs_pkg::LHS_USE)
		else $error("outputs on or use mode left");
	flag_clear_a: assert property (ce && wr_diag && !set_ok && !reject |=> !done_flag && !fail_flag)
		else $error("diagnostic write did not clear flags");
	reject_a: assert property (ce && reject |=> fail_flag && !done_flag && eng == lhs_pkg::LHS_E_IDLE)
		else $error("forbidden address not rejected");
	refresh_a: assert property (s_refresh |=> s_restart)
		else $error("refresh did not restart the counter");
	silent_a: assert property (ce && fs_latched |=> ch_on == 2'h0 && fs_latched)
		else $error("outputs on after fail-silent");

endmodule : lhs_supervisor

/* File: test_lhs_supervisor.sv */
// Purpose: self-checking bench for the fallback supervisor
// Assumes: shortened time-out unit and programming time
// Notes:   memory returns to defaults on reset, so overrides are the factory default ones
`timescale 1ns/1ns
module test_lhs_supervisor;
	localparam int unsigned UNIT = 20;
	logic        core_clk;
	logic        rst_n;
	logic        ce;
	logic        fs;
	logic        uv;
	logic [1:0]  dim;
	logic [1:0]  mreq;
	logic        reg_wr;
	logic        reg_rd;
	logic [6:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic [1:0]  ch_on;
	logic        limp_status;
	logic [63:0] limp_values;
	logic [7:0]  d;
	logic [7:0]  f;
	logic [15:0] w;
	int          err_total;
	int          num_checks;

	lhs_supervisor #(.TIMEOUT_UNIT_CYCLES(UNIT), .PROG_CYCLES(4)) lhs_supervisor_i (
		.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.channel_dimming_input(dim), .fail_silent_in(fs), .undervoltage_in(uv),
		.mem_mode_req(mreq), .ch_on(ch_on), .limp_status(limp_status), .limp_values(limp_values));

	lhs_host lhs_host_i (
		.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));

	// free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	// bounded wait on the mode flag; running out ends the run
	task automatic wait_limp(input logic v, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk);
			if (limp_status === v) return;
		end
		chk(limp_status, v);
		wrap_up();
	endtask : wait_limp

	// refresh at once, the default time-out after release is short
	task automatic do_reset();
		rst_n = 1'b0;
		cyc(3);
		rst_n = 1'b1;
		lhs_host_i.refresh(3'h7);
	endtask : do_reset

	task automatic t_base();
		lhs_host_i.rd(lhs_pkg::LHS_ADDR_FB, d);
		chk(d, 8'h7e);
		$display("test base done");
	endtask : t_base

	// every setting; first pass also proves a refresh restarts the count
	task automatic t_timeout();
		cyc(100);
		for (int s = 0; s < 8; s++) begin
			lhs_host_i.refresh(s[2:0]);
			cyc((s + 1) * UNIT - 3);
			chk(limp_status, 1'b0);
			wait_limp(1'b1, 6);
			lhs_host_i.leave();
			wait_limp(1'b0, 4);
		end
		$display("test timeout done");
	endtask : t_timeout

	task automatic t_limp();
		lhs_host_i.wr(lhs_pkg::LHS_ADDR_WLO, 8'ha5);
		lhs_host_i.refresh(3'h0);
		wait_limp(1'b1, 30);
		cyc(12);
		chk(limp_values, {lhs_pkg::LHS_NVM_DEF3, lhs_pkg::LHS_NVM_DEF2, lhs_pkg::LHS_NVM_DEF1, lhs_pkg::LHS_NVM_DEF0});
		lhs_host_i.rd(lhs_pkg::LHS_ADDR_FB, d);
		chk(d[7], 1'b1);
		lhs_host_i.wr(lhs_pkg::LHS_ADDR_WLO, 8'h5a);
		lhs_host_i.rd(lhs_pkg::LHS_ADDR_WLO, d);
		chk(d, 8'ha5);
		dim = 2'h2;
		cyc(6);
		chk(ch_on, 2'h2);
		uv = 1'b1;
		cyc(6);
		chk(ch_on, 2'h0);
		uv = 1'b0;
		cyc(6);
		chk(ch_on, 2'h2);
		// broken sequence must not release the mode
		lhs_host_i.wr(lhs_pkg::LHS_ADDR_FB, 8'h1e);
		lhs_host_i.wr(lhs_pkg::LHS_ADDR_FB, 8'h2e);
		lhs_host_i.wr(lhs_pkg::LHS_ADDR_FB, 8'h1e);
		lhs_host_i.wr(lhs_pkg::LHS_ADDR_FB, 8'h4e);
		cyc(3);
		chk(limp_status, 1'b1);
		lhs_host_i.leave();
		wait_limp(1'b0, 4);
		chk(limp_values, {lhs_pkg::LHS_NVM_DEF3, lhs_pkg::LHS_NVM_DEF2, lhs_pkg::LHS_NVM_DEF1, lhs_pkg::LHS_NVM_DEF0});
		lhs_host_i.wr(lhs_pkg::LHS_ADDR_WLO, 8'h5a);
		lhs_host_i.rd(lhs_pkg::LHS_ADDR_WLO, d);
		chk(d, 8'h5a);
		dim = 2'h1;
		cyc(6);
		chk(ch_on, 2'h1);
		fs = 1'b1;
		cyc(6);
		fs = 1'b0;
		cyc(6);
		chk(ch_on, 2'h0);
		$display("test fallback done");
	endtask : t_limp

	task automatic t_mem();
		mreq = lhs_pkg::LHS_REQ_USE;
		dim = 2'h3;
		cyc(6);
		chk(ch_on, 2'h0);
		lhs_host_i.rd(lhs_pkg::LHS_ADDR_FB, d);
		chk(d[0], 1'b1);
		lhs_host_i.mem_wr(5'h13, 16'h1234, f);
		chk(f[4:3], 2'h1);
		lhs_host_i.mem_rd(5'h13, f, w);
		chk(f[4:3], 2'h1);
		chk(w, 16'h1234);
		lhs_host_i.mem_wr(5'h05, 16'hffff, f);
		chk(f[4:3], 2'h2);
		lhs_host_i.wr(lhs_pkg::LHS_ADDR_DIAG, 8'hff);
		lhs_host_i.rd(lhs_pkg::LHS_ADDR_DIAG, d);
		chk(d[4:3], 2'h0);
		chk(limp_status, 1'b0);
		$display("test memory done");
	endtask : t_mem

	// counter must freeze while access mode lasts, and while the enable is low
	task automatic t_access();
		lhs_host_i.refresh(3'h0);
		ce = 1'b0;
		cyc(40);
		chk(limp_status, 1'b0);
		ce = 1'b1;
		mreq = lhs_pkg::LHS_REQ_ACCESS;
		dim = 2'h1;
		cyc(60);
		chk(limp_status, 1'b0);
		chk(ch_on, 2'h1);
		lhs_host_i.rd(lhs_pkg::LHS_ADDR_FB, d);
		chk(d[0], 1'b1);
		$display("test access done");
	endtask : t_access

	task automatic t_unused();
		lhs_host_i.wr(lhs_pkg::LHS_ADDR_WLO, 8'hc3);
		mreq = lhs_pkg::LHS_REQ_UNUSED;
		dim = 2'h3;
		cyc(6);
		chk(ch_on, 2'h0);
		lhs_host_i.wr(lhs_pkg::LHS_ADDR_WLO, 8'h3c);
		lhs_host_i.rd(lhs_pkg::LHS_ADDR_WLO, d);
		chk(d, 8'hc3);
		$display("test unused done");
	endtask : t_unused

	// main sequence, a reset between independent scenarios
	initial begin
		err_total = 0;
		num_checks = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		fs = 1'b0;
		uv = 1'b0;
		dim = 2'h0;
		mreq = lhs_pkg::LHS_REQ_NONE;
		do_reset();
		t_base();
		t_timeout();
		t_limp();
		do_reset();
		t_mem();
		mreq = lhs_pkg::LHS_REQ_NONE;
		do_reset();
		t_access();
		mreq = lhs_pkg::LHS_REQ_NONE;
		do_reset();
		t_unused();
		wrap_up();
	end
endmodule : test_lhs_supervisor
